//--- smc_cfg_filter.sv
/*
  Continuous level filter for the configuration pin: the level counts as
  stable once unchanged for the filter time. Input must be synchronised.
*/
`timescale 1ns/1ps
module smc_cfg_filter
  import smc_pkg::*;
#(
  parameter int unsigned FILTER_CYC = CONFIG_FILTER_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Sampling
  input  wire logic clear,
  input  wire logic level_in,
  output logic      stable,
  output logic      level_out
);

  localparam int unsigned CW = $clog2(FILTER_CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(FILTER_CYC);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic [CW-1:0] cnt;
  logic          last;

  // ==========================================================
  // Stability counter; restarts on every level change
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= '0;
      last <= 1'b0;
    end else if (clear) begin
      cnt  <= '0;
      last <= level_in;
    end else if (level_in != last) begin
      cnt  <= '0;
      last <= level_in;
    end else if (cnt != CNT_MAX) begin
      cnt <= cnt + CNT_ONE;
    end
  end

  assign stable    = (cnt == CNT_MAX);
  assign level_out = last;

endmodule

//--- smc_mcu_model.sv
/*
  Controller-side model for the mode controller: issues decoded SPI frames
  and watchdog triggers, and models the board around the configuration pin.
  Assumes it shares sys_clk with the device and is commanded by the bench.
*/
`timescale 1ns/1ps
module smc_mcu_model
  import smc_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Board choices
  input  wire logic        pull_up_fitted,
  input  wire logic        pin_noisy,
  // Configuration pin, device side
  input  wire logic        irq_config_out,
  input  wire logic        irq_config_oe,
  output logic             irq_config_in,
  // Frame decoder side
  output logic             spi_frame_done,
  output logic [15:0]      spi_frame,
  output logic             spi_mode_write,
  output logic [2:0]       spi_mode_value,
  output logic             spi_clear_por,
  output logic             wd_trigger
);
  logic toggle;

  initial begin
    toggle = 1'b0;
    spi_frame_done = 1'b0;
    spi_frame = 16'h0000;
    spi_mode_write = 1'b0;
    spi_mode_value = 3'h0;
    spi_clear_por = 1'b0;
    wd_trigger = 1'b0;
  end

  always @(posedge sys_clk) begin
    toggle <= ~toggle;
  end

  // ==========================================================
  // Pin level
  // The external pull-up beats the weak pull-down; a bare released pin floats,
  // so it shows a changing pattern instead of a settled level
  always_comb begin
    if (pin_noisy)
      irq_config_in = toggle;
    else if (pull_up_fitted)
      irq_config_in = 1'b1;
    else if (!irq_config_oe)
      irq_config_in = irq_config_out;
    else
      irq_config_in = toggle;
  end

  // ==========================================================
  // One whole frame per call, held for exactly one sampling edge
  task automatic send_frame(input logic wr, input logic [2:0] mode, input logic [15:0] data,
                            input logic trig, input logic clr);
    @(posedge sys_clk);
    #1;
    spi_frame_done = 1'b1;
    spi_frame = data;
    spi_mode_write = wr;
    spi_mode_value = mode;
    wd_trigger = trig;
    spi_clear_por = clr;
    @(posedge sys_clk);
    #1;
    spi_frame_done = 1'b0;
    spi_frame = ~data;
    spi_mode_write = 1'b0;
    spi_mode_value = ~mode;
    wd_trigger = 1'b0;
    spi_clear_por = 1'b0;
  endtask
endmodule

//--- smc_mode_ctrl.sv
/*
  Operating-mode state machine with power-up configuration sampling,
  development-mode latch and watchdog / overvoltage failure reactions.
  Assumes the SPI frame decoder, watchdog and supply monitors are neighbours
  on sys_clk; pins are synchronised here. arst_n is the power-on reset.
*/
`timescale 1ns/1ps
module smc_mode_ctrl
  import smc_pkg::*;
#(
  parameter int unsigned RD_CYC = RESET_DELAY_CYC,
  parameter int unsigned LW_CYC = LONG_OPEN_WINDOW_CYC,
  parameter int unsigned CF_CYC = CONFIG_FILTER_CYC
) (
  // Clock and power-on reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // SPI frame decoder
  input  wire logic       spi_frame_done,
  input  wire logic [15:0] spi_frame,
  input  wire logic       spi_mode_write,
  input  wire logic [2:0] spi_mode_value,
  input  wire logic       spi_clear_por,
  // Watchdog and supply monitors
  input  wire logic       wd_trigger,
  input  wire logic       wd_failure,
  input  wire logic       main_undervoltage,
  input  wire logic       main_overvoltage,
  input  wire logic       overvoltage_reset_enable,
  input  wire logic       overtemp_shutdown,
  input  wire logic       fail_count_select,
  // Wake sources
  input  wire logic       wake_can,
  input  wire logic       wake_lin,
  input  wire logic       wake_inputs,
  // Pins
  input  wire logic       test_pin,
  input  wire logic       irq_config_in,
  output logic            irq_config_out,
  output logic            irq_config_oe,
  output logic            reset_output_pin,
  output logic            fail_output_pins,
  output logic            main_supply_on,
  // Status
  output logic [2:0]      mode_select_bits,
  output logic [2:0]      mode_state,
  output logic            pin_config_select,
  output logic            hw_fail_count_select,
  output logic            main_overvoltage_flag,
  output logic            power_on_flag,
  output logic            dev_mode,
  output logic            wd_halt,
  output logic            wd_long_window,
  output logic            wd_configured,
  output logic            wake_event
);

  localparam int unsigned RW = $clog2(RD_CYC + 1);
  localparam int unsigned LWW = $clog2(LW_CYC + 1);
  localparam logic [RW-1:0]  RD_LAST = RW'(RD_CYC - 1);
  localparam logic [RW-1:0]  RD_ONE  = RW'(1);
  localparam logic [LWW-1:0] LW_LAST = LWW'(LW_CYC - 1);
  localparam logic [LWW-1:0] LW_ONE  = LWW'(1);

  smc_mode_t mode;
  smc_mode_t next_mode;
  logic [1:0] wd_fail_cnt;
  logic [RW-1:0] rd_cnt;
  logic [LWW-1:0] lw_cnt;
  logic cfg_s1, cfg_s2, test_s1, test_s2;
  logic flt_stable, flt_level;
  logic ov_d;
  logic ov_rise;
  logic ot_d;
  logic ot_fall;
  logic wd_fail_ev;
  logic any_wake;
  logic rd_done;
  logic first_cfg_done;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_s1  <= 1'b0;
      cfg_s2  <= 1'b0;
      test_s1 <= 1'b1;
      test_s2 <= 1'b1;
    end else begin
      cfg_s1  <= irq_config_in;
      cfg_s2  <= cfg_s1;
      test_s1 <= test_pin;
      test_s2 <= test_s1;
    end
  end

  smc_cfg_filter #(
    .FILTER_CYC (CF_CYC)
  ) u_filter (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .clear     (reset_output_pin),
    .level_in  (cfg_s2),
    .stable    (flt_stable),
    .level_out (flt_level)
  );

  // ==========================================================
  // Events
  assign ov_rise    = main_overvoltage && !ov_d;
  // Besides a wake, only a release of overtemperature ends fail-safe; a low level alone would let
  // a watchdog failure pass straight through fail-safe
  assign ot_fall    = ot_d && !overtemp_shutdown;
  assign any_wake   = wake_can || wake_lin || wake_inputs;
  // Development mode halts the watchdog, so no failure is ever seen
  assign wd_fail_ev = !dev_mode && (wd_failure ||
                      (wd_long_window && !wd_configured && lw_cnt == LW_LAST));
  assign rd_done    = (rd_cnt == RD_LAST);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ov_d <= 1'b0;
      ot_d <= 1'b0;
    end else begin
      ov_d <= main_overvoltage;
      ot_d <= overtemp_shutdown;
    end
  end

  // ==========================================================
  // Next mode
  always_comb begin
    next_mode = mode;
    case (mode)
      SMC_INIT: begin
        if (spi_frame_done) begin
          next_mode = SMC_NORMAL;
        end
      end
      SMC_NORMAL, SMC_STOP: begin
        if (spi_frame_done && spi_mode_write) begin
          case (spi_mode_value)
            SMC_NORMAL:    next_mode = SMC_NORMAL;
            SMC_STOP:      next_mode = SMC_STOP;
            SMC_SLEEP:     next_mode = (mode == SMC_STOP) ? SMC_RESTART : SMC_SLEEP;
            SMC_RESTART:   next_mode = SMC_RESTART;
            SMC_FAIL_SAFE: next_mode = SMC_FAIL_SAFE;
            default:       next_mode = mode;
          endcase
        end
      end
      SMC_SLEEP: begin
        if (any_wake) begin
          next_mode = SMC_RESTART;
        end
      end
      SMC_RESTART: begin
        if (rd_done && !main_undervoltage) begin
          next_mode = SMC_NORMAL;
        end
      end
      SMC_FAIL_SAFE: begin
        if (any_wake || ot_fall) begin
          next_mode = SMC_RESTART;
        end
      end
      default: next_mode = SMC_INIT;
    endcase
    // Failure reactions override software requests
    if (mode != SMC_FAIL_SAFE && mode != SMC_SLEEP) begin
      if (main_undervoltage && mode != SMC_INIT) begin
        next_mode = SMC_RESTART;
      end
      if (ov_rise && overvoltage_reset_enable) begin
        next_mode = pin_config_select ? SMC_RESTART : SMC_FAIL_SAFE;
      end
      if (wd_fail_ev) begin
        if (pin_config_select) begin
          next_mode = SMC_RESTART;
        end else if (!hw_fail_count_select && wd_fail_cnt == FAIL_CNT_ZERO) begin
          next_mode = SMC_RESTART;
        end else begin
          next_mode = SMC_FAIL_SAFE;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= SMC_INIT;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================================
  // Mode select bits: software view, zero after restart
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_select_bits <= MODE_SEL_CLEAR;
    end else if (next_mode == SMC_RESTART) begin
      mode_select_bits <= MODE_SEL_CLEAR;
    end else if ((mode == SMC_NORMAL || mode == SMC_STOP) && spi_frame_done && spi_mode_write) begin
      // Follow the mode actually taken, so refused or unknown codes never show
      mode_select_bits <= next_mode;
    end
  end

  // ==========================================================
  // Reset delay: reset output low in init start-up, restart and fail-safe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_cnt           <= '0;
      reset_output_pin <= 1'b0;
    end else if (mode == SMC_RESTART && next_mode == SMC_RESTART && !rd_done) begin
      rd_cnt           <= rd_cnt + RD_ONE;
      reset_output_pin <= 1'b0;
    end else if (mode == SMC_INIT && !reset_output_pin) begin
      rd_cnt           <= rd_done ? rd_cnt : rd_cnt + RD_ONE;
      reset_output_pin <= rd_done;
    end else if (mode == SMC_RESTART || next_mode == SMC_RESTART || mode == SMC_FAIL_SAFE) begin
      rd_cnt           <= (mode == SMC_RESTART) ? rd_cnt : '0;
      reset_output_pin <= 1'b0;
    end else begin
      rd_cnt           <= '0;
      reset_output_pin <= 1'b1;
    end
  end

  // ==========================================================
  // Configuration sampling; pull-down while reset output low and power_on_flag set
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_config_oe     <= 1'b1;
      irq_config_out    <= 1'b0;
      pin_config_select <= CFG_DEFAULT;
      power_on_flag     <= 1'b1;
    end else begin
      irq_config_out <= 1'b0;
      // Active-low enable: drive weak low only while sampling
      irq_config_oe  <= !(power_on_flag && !reset_output_pin);
      if (power_on_flag && !reset_output_pin && rd_done) begin
        pin_config_select <= flt_stable ? flt_level : CFG_DEFAULT;
      end
      if (spi_clear_por) begin
        power_on_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Development mode latch, only while in init
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_mode <= 1'b0;
    end else if (mode == SMC_INIT && !test_s2) begin
      dev_mode <= 1'b1;
    end
  end

  // ==========================================================
  // Long open window and first-trigger configuration
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lw_cnt         <= '0;
      wd_long_window <= 1'b1;
      wd_configured  <= 1'b0;
    end else if (wd_long_window && wd_trigger) begin
      wd_long_window <= 1'b0;
      wd_configured  <= 1'b1;
    end else if (wd_long_window && !dev_mode) begin
      if (lw_cnt == LW_LAST) begin
        wd_long_window <= 1'b0;
      end else begin
        lw_cnt <= lw_cnt + LW_ONE;
      end
    end
  end

  // ==========================================================
  // Failure counting and fail outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_fail_cnt      <= FAIL_CNT_ZERO;
      fail_output_pins <= 1'b0;
    end else begin
      if (wd_fail_ev && wd_fail_cnt != FAIL_CNT_TWO) begin
        wd_fail_cnt <= wd_fail_cnt + FAIL_CNT_ONE;
      end
      if (wd_fail_ev && (hw_fail_count_select || wd_fail_cnt != FAIL_CNT_ZERO)) begin
        fail_output_pins <= 1'b1;
      end
      if (ov_rise && overvoltage_reset_enable) begin
        fail_output_pins <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      main_overvoltage_flag <= 1'b0;
    end else if (ov_rise) begin
      main_overvoltage_flag <= 1'b1;
    end
  end

  // ==========================================================
  // Status and supply outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_state           <= SMC_INIT;
      hw_fail_count_select <= 1'b0;
      main_supply_on       <= 1'b1;
      wd_halt              <= 1'b0;
      wake_event           <= 1'b0;
    end else begin
      mode_state           <= next_mode;
      hw_fail_count_select <= fail_count_select;
      main_supply_on       <= !(next_mode == SMC_FAIL_SAFE || next_mode == SMC_SLEEP);
      wd_halt              <= dev_mode;
      wake_event           <= any_wake && mode != SMC_INIT;
    end
  end

  // ==========================================================
  // Checks
  property p_restart_clears;
    @(posedge sys_clk) disable iff (!arst_n) mode == SMC_RESTART |-> mode_select_bits == MODE_SEL_CLEAR;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("select bits not clear");

  property p_init_spi;
    @(posedge sys_clk) disable iff (!arst_n)
      (mode == SMC_INIT && spi_frame_done && !wd_fail_ev && !ov_rise) |=> mode == SMC_NORMAL;
  endproperty
  a_init_spi: assert property (p_init_spi) else $error("init did not leave on spi");

  property p_failsafe_supply;
    @(posedge sys_clk) disable iff (!arst_n) mode == SMC_FAIL_SAFE |-> !main_supply_on;
  endproperty
  a_failsafe_supply: assert property (p_failsafe_supply) else $error("supply on in fail-safe");

  property p_ov_flag;
    @(posedge sys_clk) disable iff (!arst_n) ov_rise |=> main_overvoltage_flag;
  endproperty
  a_ov_flag: assert property (p_ov_flag) else $error("overvoltage flag not set");

  property p_ov_restart;
    @(posedge sys_clk) disable iff (!arst_n)
      (ov_rise && overvoltage_reset_enable && pin_config_select && !wd_fail_ev
       && mode != SMC_FAIL_SAFE && mode != SMC_SLEEP) |=> mode == SMC_RESTART;
  endproperty
  a_ov_restart: assert property (p_ov_restart) else $error("overvoltage restart missed");

  property p_ov_failsafe;
    @(posedge sys_clk) disable iff (!arst_n)
      (ov_rise && overvoltage_reset_enable && !pin_config_select && !wd_fail_ev
       && mode != SMC_FAIL_SAFE && mode != SMC_SLEEP) |=> mode == SMC_FAIL_SAFE;
  endproperty
  a_ov_failsafe: assert property (p_ov_failsafe) else $error("overvoltage fail-safe missed");

  sequence s_restart_with_fail;
    mode == SMC_RESTART ##0 (fail_output_pins || !hw_fail_count_select);
  endsequence

  property p_wd_cfg1;
    @(posedge sys_clk) disable iff (!arst_n)
      (wd_fail_ev && pin_config_select && mode != SMC_FAIL_SAFE && mode != SMC_SLEEP)
      |=> s_restart_with_fail;
  endproperty
  a_wd_cfg1: assert property (p_wd_cfg1) else $error("watchdog restart missed");

  property p_dev_halt;
    @(posedge sys_clk) disable iff (!arst_n) dev_mode |-> ##1 wd_halt ##0 !wd_fail_ev;
  endproperty
  a_dev_halt: assert property (p_dev_halt) else $error("watchdog not halted");

  property p_cfg_stable;
    @(posedge sys_clk) disable iff (!arst_n) !power_on_flag |=> $stable(pin_config_select);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config changed");

endmodule

//--- smc_pkg.sv
/*
  Package for the operating-mode and hardware-configuration controller:
  mode encodings, timing figures, fail counting constants.
  Assumes a 250 MHz system clock.
*/
package smc_pkg;

  // ==========================================================
  // Clock
  localparam int unsigned CLK_MHZ             = 250;

  // ==========================================================
  // Timing figures, in microseconds and milliseconds, and derived cycle counts
  localparam int unsigned RESET_DELAY_US      = 10;
  localparam int unsigned CONFIG_FILTER_US    = 2;
  localparam int unsigned LONG_OPEN_WINDOW_MS = 200;
  localparam int unsigned RESET_DELAY_CYC     = RESET_DELAY_US * CLK_MHZ;
  localparam int unsigned CONFIG_FILTER_CYC   = CONFIG_FILTER_US * CLK_MHZ;
  localparam int unsigned LONG_OPEN_WINDOW_CYC = LONG_OPEN_WINDOW_MS * 1000 * CLK_MHZ;

  // ==========================================================
  // Mode encodings, also the value of mode_select_bits
  typedef enum logic [2:0] {
    SMC_INIT      = 3'b000,
    SMC_NORMAL    = 3'b001,
    SMC_STOP      = 3'b010,
    SMC_SLEEP     = 3'b011,
    SMC_RESTART   = 3'b100,
    SMC_FAIL_SAFE = 3'b101
  } smc_mode_t;

  localparam logic [2:0] MODE_SEL_CLEAR = 3'h0;
  localparam logic [1:0] FAIL_CNT_ZERO  = 2'h0;
  localparam logic [1:0] FAIL_CNT_ONE   = 2'h1;
  localparam logic [1:0] FAIL_CNT_TWO   = 2'h2;
  localparam logic       CFG_DEFAULT    = 1'b0;

endpackage

//--- system_mode_config_init_tb_top.sv
/*
  Self-checking bench for the mode controller: table of configuration and
  failure cases, then reset, watchdog window, development mode and noisy pin.
  Assumes shortened counts RD=20, LW=200, CF=5 cycles.
*/
`timescale 1ns/1ps
module system_mode_config_init_tb_top;
  import smc_pkg::*;
  localparam int RD = 20;
  typedef struct packed {
    logic pu; logic fcs; logic ov; logic ovr; logic [2:0] m1; logic f1; logic wk;
  } smc_tb_row_t;

  logic sys_clk, arst_n, spi_frame_done, spi_mode_write, spi_clear_por, wd_trigger, wd_failure;
  logic main_undervoltage, main_overvoltage, overvoltage_reset_enable, overtemp_shutdown;
  logic fail_count_select, wake_can, wake_lin, wake_inputs, test_pin, irq_config_in;
  logic irq_config_out, irq_config_oe, reset_output_pin, fail_output_pins, main_supply_on;
  logic pin_config_select, hw_fail_count_select, main_overvoltage_flag, power_on_flag;
  logic dev_mode, wd_halt, wd_long_window, wd_configured, wake_event, pull_up, noisy, seen;
  logic [15:0] spi_frame;
  logic [2:0] spi_mode_value, mode_select_bits, mode_state;
  int failures, total_checks, n;
  smc_tb_row_t r;
  smc_tb_row_t rows [7];
  logic [2:0] wm [4];
  logic [2:0] we [4];

  smc_mode_ctrl #(.RD_CYC(20), .LW_CYC(200), .CF_CYC(5)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .spi_frame_done(spi_frame_done), .spi_frame(spi_frame),
    .spi_mode_write(spi_mode_write), .spi_mode_value(spi_mode_value), .spi_clear_por(spi_clear_por),
    .wd_trigger(wd_trigger), .wd_failure(wd_failure), .main_undervoltage(main_undervoltage),
    .main_overvoltage(main_overvoltage), .overvoltage_reset_enable(overvoltage_reset_enable),
    .overtemp_shutdown(overtemp_shutdown), .fail_count_select(fail_count_select),
    .wake_can(wake_can), .wake_lin(wake_lin), .wake_inputs(wake_inputs), .test_pin(test_pin),
    .irq_config_in(irq_config_in), .irq_config_out(irq_config_out), .irq_config_oe(irq_config_oe),
    .reset_output_pin(reset_output_pin), .fail_output_pins(fail_output_pins),
    .main_supply_on(main_supply_on), .mode_select_bits(mode_select_bits), .mode_state(mode_state),
    .pin_config_select(pin_config_select), .hw_fail_count_select(hw_fail_count_select),
    .main_overvoltage_flag(main_overvoltage_flag), .power_on_flag(power_on_flag),
    .dev_mode(dev_mode), .wd_halt(wd_halt), .wd_long_window(wd_long_window),
    .wd_configured(wd_configured), .wake_event(wake_event));

  smc_mcu_model mcu (
    .sys_clk(sys_clk), .pull_up_fitted(pull_up), .pin_noisy(noisy), .irq_config_out(irq_config_out),
    .irq_config_oe(irq_config_oe), .irq_config_in(irq_config_in), .spi_frame_done(spi_frame_done),
    .spi_frame(spi_frame), .spi_mode_write(spi_mode_write), .spi_mode_value(spi_mode_value),
    .spi_clear_por(spi_clear_por), .wd_trigger(wd_trigger));

  always #2 sys_clk = ~sys_clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    tick(10);
    arst_n = 1'b1;
  endtask

  // Bounded wait for the reset output to be released; checks the cycle count against RD
  task automatic wait_ro();
    n = 0;
    while (reset_output_pin !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check((n >= RD - 4 && n <= RD + 3), 1'b1);
  endtask

  task automatic fire(input logic ov, input logic hot);
    if (ov)
      main_overvoltage = 1'b1;
    else
      wd_failure = 1'b1;
    overtemp_shutdown = hot;
    tick(1);
    main_overvoltage = 1'b0;
    wd_failure = 1'b0;
    tick(2);
  endtask

  // Wake events may show one cycle late, so several cycles are watched
  task automatic wake_probe();
    seen = 1'b0;
    wake_can = 1'b1;
    tick(1);
    wake_can = 1'b0;
    repeat (4) begin
      seen = seen | (wake_event === 1'b1);
      tick(1);
    end
  endtask

  initial begin
    {sys_clk, arst_n, wd_failure, main_undervoltage, main_overvoltage, overtemp_shutdown} = '0;
    {overvoltage_reset_enable, fail_count_select, wake_can, wake_lin, wake_inputs, noisy} = '0;
    test_pin = 1'b1;
    pull_up = 1'b1;
    failures = 0;
    total_checks = 0;
    rows = '{{1'b1, 1'b1, 1'b0, 1'b0, SMC_RESTART, 1'b1, 1'b0}, {1'b1, 1'b0, 1'b0, 1'b0, SMC_RESTART, 1'b0, 1'b0},
             {1'b0, 1'b1, 1'b0, 1'b0, SMC_FAIL_SAFE, 1'b1, 1'b1}, {1'b0, 1'b0, 1'b0, 1'b0, SMC_RESTART, 1'b0, 1'b0},
             {1'b1, 1'b1, 1'b1, 1'b0, SMC_NORMAL, 1'b0, 1'b0}, {1'b1, 1'b0, 1'b1, 1'b1, SMC_RESTART, 1'b1, 1'b0},
             {1'b0, 1'b0, 1'b1, 1'b1, SMC_FAIL_SAFE, 1'b1, 1'b0}};
    wm = '{SMC_STOP, SMC_NORMAL, SMC_STOP, SMC_SLEEP};
    we = '{SMC_STOP, SMC_NORMAL, SMC_STOP, SMC_RESTART};
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      pull_up = r.pu;
      fail_count_select = r.fcs;
      overvoltage_reset_enable = r.ovr;
      overtemp_shutdown = 1'b0;
      do_reset();
      wait_ro();
      check(pin_config_select, r.pu);
      check(hw_fail_count_select, r.fcs);
      mcu.send_frame(1'b0, SMC_INIT, 16'hA5A5, 1'b1, 1'b0);
      tick(1);
      check(mode_state, SMC_NORMAL);
      check(wd_configured, 1'b1);
      fire(r.ov, r.m1 == SMC_FAIL_SAFE);
      check(mode_state, r.m1);
      check(fail_output_pins, r.f1);
      if (r.ov)
        check(main_overvoltage_flag, 1'b1);
      if (r.m1 == SMC_RESTART) begin
        check(mode_select_bits, MODE_SEL_CLEAR);
        wait_ro();
        tick(2);
        check(mode_state, SMC_NORMAL);
        if (!r.ov) begin
          fire(1'b0, !r.pu);
          check(mode_state, r.pu ? SMC_RESTART : SMC_FAIL_SAFE);
          check(fail_output_pins, 1'b1);
        end
      end
      if (r.m1 == SMC_FAIL_SAFE) begin
        check(main_supply_on, 1'b0);
        tick(5);
        check(mode_state, SMC_FAIL_SAFE);
        if (r.wk) begin
          wake_probe();
          check(seen, 1'b1);
        end else begin
          overtemp_shutdown = 1'b0;
          tick(5);
        end
        wait_ro();
        tick(2);
        check(mode_state, SMC_NORMAL);
      end
      $display("Table case %0d done", i);
    end
    overtemp_shutdown = 1'b0;
    pull_up = 1'b1;
    do_reset();
    check(mode_state, SMC_INIT);
    check({wd_long_window, power_on_flag, main_supply_on, fail_output_pins}, 4'hE);
    tick(3);
    check({irq_config_oe, irq_config_out}, 2'h0);
    wait_ro();
    wake_probe();
    check(seen, 1'b0);
    n = 0;
    while (mode_state !== SMC_RESTART && n < 400) begin
      tick(1);
      n++;
    end
    check(mode_state, SMC_RESTART);
    wait_ro();
    tick(2);
    mcu.send_frame(1'b0, SMC_INIT, 16'h0F0F, 1'b1, 1'b1);
    tick(1);
    check(power_on_flag, 1'b0);
    check(pin_config_select, 1'b1);
    wake_probe();
    check(seen, 1'b1);
    // With the flag cleared a restart must not resample the now floating pin
    pull_up = 1'b0;
    mcu.send_frame(1'b1, SMC_RESTART, 16'h0F0F, 1'b0, 1'b0);
    tick(1);
    check(mode_state, SMC_RESTART);
    wait_ro();
    check(pin_config_select, 1'b1);
    check(irq_config_oe, 1'b1);
    pull_up = 1'b1;
    $display("Power-up and window test done");
    test_pin = 1'b0;
    do_reset();
    wait_ro();
    check({dev_mode, wd_halt}, 2'h3);
    mcu.send_frame(1'b0, SMC_INIT, 16'hFFFF, 1'b0, 1'b0);
    tick(1);
    check(mode_state, SMC_NORMAL);
    fire(1'b0, 1'b0);
    check(mode_state, SMC_NORMAL);
    for (int k = 0; k < 4; k++) begin
      mcu.send_frame(1'b1, wm[k], 16'h1234, 1'b0, 1'b0);
      tick(1);
      check(mode_state, we[k]);
      check(mode_select_bits, (k < 3) ? we[k] : MODE_SEL_CLEAR);
    end
    wait_ro();
    tick(2);
    mcu.send_frame(1'b1, SMC_SLEEP, 16'h1234, 1'b0, 1'b0);
    tick(1);
    check(mode_state, SMC_SLEEP);
    check({main_supply_on, mode_select_bits}, {1'b0, SMC_SLEEP});
    test_pin = 1'b1;
    $display("Development mode test done");
    noisy = 1'b1;
    do_reset();
    wait_ro();
    check(pin_config_select, 1'b0);
    noisy = 1'b0;
    $display("Unstable pin test done");
    stop_test();
  end

  initial begin
    #80000;
    failures++;
    stop_test();
  end
endmodule
